// *** hw/sdc_pkg.sv ***
package sdc_pkg;

  // ----------------------------------------------------------------
  // clocking and decimation
  // ----------------------------------------------------------------
  localparam int SYS_CLK_HZ = 250_000_000;
  localparam int MOD_RATE_HZ = 1_536_000;
  // modulator bit period in system cycles, rounded down
  localparam int MOD_DIV_CYC = SYS_CLK_HZ / MOD_RATE_HZ;
  localparam int DIV_W = 8;
  localparam int SINC_ORDER = 4;
  localparam int OSR_HI = 8;
  localparam int OSR_LO = 4;
  localparam int OSR_CNT_W = 3;
  localparam int PRIME_CONV = 3;
  localparam int PRIME_W = 2;

  // ----------------------------------------------------------------
  // result format
  // ----------------------------------------------------------------
  localparam int RES_W = 12;
  localparam logic [RES_W-1:0] RES_MAX_HI = 12'hfff;
  localparam logic [RES_W-1:0] RES_MAX_LO = 12'h0ff;
  localparam logic [RES_W-1:0] RES_RST = 12'h000;

  // ----------------------------------------------------------------
  // control word fields
  // ----------------------------------------------------------------
  localparam int CTRL_W = 5;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RES8_BIT = 2;
  localparam int CTRL_START_BIT = 3;
  localparam int CTRL_STOP_BIT = 4;

  // ----------------------------------------------------------------
  // status word fields
  // ----------------------------------------------------------------
  localparam int STAT_W = 5;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_MODE_LSB = 2;
  localparam int STAT_RES8_BIT = 4;

  // ----------------------------------------------------------------
  // controller register port
  // ----------------------------------------------------------------
  localparam int ADDR_W = 2;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESULT = 2'h1;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_MULTI = 2'b01,
    MODE_CONT = 2'b10,
    MODE_TURBO = 2'b11
  } sdc_mode_type;

  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_RUN = 2'b01,
    ST_HOLD = 2'b10,
    ST_GAP = 2'b11
  } sdc_state_type;

endpackage : sdc_pkg

// *** hw/sdc_link_if.sv ***
`timescale 1ns/100ps
interface sdc_link_if;
  import sdc_pkg::*;

  // ----------------------------------------------------------------
  // controller to converter
  // ----------------------------------------------------------------
  logic ctl_wr;
  logic [CTRL_W-1:0] ctl_wdata;
  logic soc;
  logic res_rd;

  // ----------------------------------------------------------------
  // converter to controller
  // ----------------------------------------------------------------
  logic [RES_W-1:0] res_data;
  logic eoc;
  logic [STAT_W-1:0] stat;

  modport dev (
    input ctl_wr,
    input ctl_wdata,
    input soc,
    input res_rd,
    output res_data,
    output eoc,
    output stat
  );

  modport ctl (
    output ctl_wr,
    output ctl_wdata,
    output soc,
    output res_rd,
    input res_data,
    input eoc,
    input stat
  );
endinterface : sdc_link_if

// *** hw/sdc_sinc4.sv ***
`timescale 1ns/100ps
module sdc_sinc4 import sdc_pkg::*; #(
  parameter int ACC_W = 16
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clr,
  input wire logic bit_en,
  input wire logic bit_in,
  input wire logic res8,
  output logic [RES_W-1:0] out_q,
  output logic out_vld_q
);

  logic [ACC_W-1:0] acc_q [SINC_ORDER];
  logic [ACC_W-1:0] dly_q [SINC_ORDER];
  logic [ACC_W-1:0] diff [SINC_ORDER+1];
  logic [OSR_CNT_W-1:0] phase_q;
  logic [OSR_CNT_W-1:0] last_phase;
  logic [RES_W-1:0] top;
  logic dec_tick;

  // ----------------------------------------------------------------
  // decimation phase
  // ----------------------------------------------------------------
  // shorter ratio trades resolution for doubled rate
  assign last_phase = res8 ? OSR_CNT_W'(OSR_LO - 1)
                           : OSR_CNT_W'(OSR_HI - 1); // see [RQ12]
  assign dec_tick = bit_en & (phase_q == last_phase);

  always_ff @(posedge sys_clk) begin
    if (srst || clr) begin
      phase_q <= '0;
    end else if (dec_tick) begin
      phase_q <= '0;
    end else if (bit_en) begin
      phase_q <= phase_q + OSR_CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // integrator chain at bit rate
  // ----------------------------------------------------------------
  // bitstream in, parallel words out
  always_ff @(posedge sys_clk) begin
    if (srst || clr) begin
      for (int i = 0; i < SINC_ORDER; i++) begin
        acc_q[i] <= '0;
      end
    end else if (bit_en) begin
      acc_q[0] <= acc_q[0] + ACC_W'(bit_in); // see [RQ13]
      for (int i = 1; i < SINC_ORDER; i++) begin
        acc_q[i] <= acc_q[i] + acc_q[i-1]; // see [RQ14]
      end
    end
  end

  // ----------------------------------------------------------------
  // comb chain at output rate
  // ----------------------------------------------------------------
  // wrap-around arithmetic is exact as span fits ACC_W
  always_comb begin
    diff[0] = acc_q[SINC_ORDER-1];
    for (int i = 0; i < SINC_ORDER; i++) begin
      diff[i+1] = diff[i] - dly_q[i]; // see [RQ14]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || clr) begin
      for (int i = 0; i < SINC_ORDER; i++) begin
        dly_q[i] <= '0;
      end
    end else if (dec_tick) begin
      for (int i = 0; i < SINC_ORDER; i++) begin
        dly_q[i] <= diff[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // output scaling
  // ----------------------------------------------------------------
  // full scale saturates at top, the largest code of the width
  assign top = res8 ? RES_MAX_LO : RES_MAX_HI;

  always_ff @(posedge sys_clk) begin
    if (srst || clr) begin
      out_q <= RES_RST;
      out_vld_q <= 1'b0;
    end else begin
      out_vld_q <= dec_tick;
      if (dec_tick) begin
        if (diff[SINC_ORDER] > ACC_W'(top)) begin
          out_q <= top;
        end else begin
          out_q <= diff[SINC_ORDER][RES_W-1:0];
        end
      end
    end
  end

endmodule : sdc_sinc4

// *** hw/sdc_adc_ctrl.sv ***
// Operation
// [RQ1] four modes: single, multi, continuous, turbo
// [RQ2] start by control start bit or trigger
// [RQ3] completion sets status and raises done
// [RQ4] single: four conversions, result after fourth
// [RQ5] single: standby, back after result transfer
// [RQ6] continuous: three conversions priming latency
// [RQ7] continuous: further results without new trigger
// [RQ8] controller keeps input fixed in continuous
// [RQ9] multi: decimator reset and reprimed per sample
// [RQ10] multi: next sample starts by itself
// [RQ11] output depends on last four samples
// [RQ12] 12 bits at 192k, 8 at 384k
// [RQ13] modulator bitstream decimated into parallel words
// [RQ14] decimation filter is sinc to fourth
// [RQ15] trigger driven by clock or logic
// [RQ16] continuous runs with trigger unconnected
// [RQ17] done rises each conversion, usable as request
// [RQ18] completion seen by poll, interrupt or DMA
// [RQ19] result read clears status and done
// [RQ20] turbo: multi sequence, done every sample
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/100ps
module sdc_adc_ctrl import sdc_pkg::*; #(
  parameter int ACC_W = 16
) (
  input wire logic sys_clk,
  input wire logic srst,
  sdc_link_if.dev link,
  input wire logic mod_bit,
  output logic mod_en
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  sdc_state_type state_q;
  sdc_mode_type mode_q;
  logic res8_q;
  logic [DIV_W-1:0] div_q;
  logic mod_tick;
  logic mod_en_q;
  logic [PRIME_W-1:0] prime_q;
  logic [RES_W-1:0] res_q;
  logic done_q;
  logic [RES_W-1:0] dec_out;
  logic dec_vld;
  logic dec_clr;
  logic start_req;
  logic stop_req;
  logic primed;
  logic take;
  logic turbo_restart;

  // ----------------------------------------------------------------
  // modulator bit clock
  // ----------------------------------------------------------------
  // one enable pulse per modulator bit period
  assign mod_tick = (div_q == DIV_W'(MOD_DIV_CYC - 1));

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      div_q <= '0;
    end else if (mod_tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DIV_W'(1);
    end
  end

  // strobe to modulator; bit sampled while it is high
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mod_en_q <= 1'b0;
    end else begin
      mod_en_q <= mod_tick;
    end
  end

  assign mod_en = mod_en_q;

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // start bit or trigger pulse, trigger may idle low
  assign start_req = (link.ctl_wr & link.ctl_wdata[CTRL_START_BIT])
                   | link.soc; // see [RQ2]
  assign stop_req = link.ctl_wr & link.ctl_wdata[CTRL_STOP_BIT];

  // mode and resolution, reloaded by every control write, start and stop writes included
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_q <= MODE_SINGLE;
      res8_q <= 1'b0;
    end else if (link.ctl_wr) begin
      mode_q <= sdc_mode_type'(
        link.ctl_wdata[CTRL_MODE_LSB +: 2]); // see [RQ1]
      res8_q <= link.ctl_wdata[CTRL_RES8_BIT]; // see [RQ12]
    end
  end

  // ----------------------------------------------------------------
  // decimator
  // ----------------------------------------------------------------
  // held clear whenever no sample is in progress
  assign dec_clr = stop_req
                 | (state_q == ST_STANDBY)
                 | (state_q == ST_HOLD)
                 | (state_q == ST_GAP) // see [RQ9]
                 | turbo_restart; // see [RQ20]

  sdc_sinc4 #(
    .ACC_W(ACC_W)
  ) u_sinc (
    .sys_clk(sys_clk),
    .srst(srst),
    .clr(dec_clr),
    .bit_en(mod_en_q),
    .bit_in(mod_bit),
    .res8(res8_q),
    .out_q(dec_out),
    .out_vld_q(dec_vld)
  );

  // ----------------------------------------------------------------
  // priming count
  // ----------------------------------------------------------------
  // first three words after a clear are discarded
  assign primed = (prime_q == PRIME_W'(PRIME_CONV)); // see [RQ11]
  assign take = (state_q == ST_RUN) & dec_vld & primed & ~stop_req;
  assign turbo_restart = take & (mode_q == MODE_TURBO);

  always_ff @(posedge sys_clk) begin
    if (srst || dec_clr) begin
      prime_q <= '0;
    end else if (dec_vld && !primed) begin
      prime_q <= prime_q + PRIME_W'(1); // see [RQ6]
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // standby, running, waiting for read, reset gap
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= ST_STANDBY;
    end else if (stop_req) begin
      state_q <= ST_STANDBY;
    end else begin
      case (state_q)
        ST_STANDBY: begin
          if (start_req) begin // see [RQ16]
            state_q <= ST_RUN; // see [RQ5]
          end
        end
        ST_RUN: begin
          if (take) begin
            case (mode_q)
              MODE_SINGLE: begin
                state_q <= ST_HOLD; // see [RQ4]
              end
              MODE_MULTI: begin
                state_q <= ST_GAP; // see [RQ9]
              end
              default: begin
                state_q <= ST_RUN; // see [RQ7]
              end
            endcase
          end
        end
        ST_HOLD: begin
          if (link.res_rd) begin
            state_q <= ST_STANDBY; // see [RQ5]
          end
        end
        ST_GAP: begin
          if (mod_en_q) begin
            state_q <= ST_RUN; // see [RQ10]
          end
        end
        default: begin
          state_q <= ST_STANDBY;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // result and completion flag
  // ----------------------------------------------------------------
  // result word held until the next completed sample
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      res_q <= RES_RST;
    end else if (take) begin
      res_q <= dec_out; // see [RQ3]
    end
  end

  // new result wins over a read in the same cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      done_q <= 1'b0;
    end else if (take) begin
      done_q <= 1'b1; // see [RQ17]
    end else if (link.res_rd) begin
      done_q <= 1'b0; // see [RQ19]
    end
  end

  // ----------------------------------------------------------------
  // link outputs
  // ----------------------------------------------------------------
  assign link.res_data = res_q;
  assign link.eoc = done_q; // see [RQ3]
  assign link.stat[STAT_DONE_BIT] = done_q; // see [RQ3]
  assign link.stat[STAT_BUSY_BIT] = (state_q != ST_STANDBY);
  assign link.stat[STAT_MODE_LSB +: 2] = mode_q;
  assign link.stat[STAT_RES8_BIT] = res8_q;

endmodule : sdc_adc_ctrl

// *** hw/sdc_host_ctl.sv ***
`timescale 1ns/100ps
module sdc_host_ctl import sdc_pkg::*; (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic ext_trig,
  output logic done_req,
  sdc_link_if.ctl link
);

  logic ctl_wr_q;
  logic [CTRL_W-1:0] ctl_wdata_q;
  logic trig_prev_q;
  logic soc_q;
  logic [DATA_W-1:0] rdata_q;

  // ----------------------------------------------------------------
  // control writes
  // ----------------------------------------------------------------
  // control word forwarded one cycle after the write
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctl_wr_q <= 1'b0;
      ctl_wdata_q <= '0;
    end else begin
      ctl_wr_q <= reg_wr & (reg_addr == ADDR_CTRL); // see [RQ2]
      if (reg_wr && reg_addr == ADDR_CTRL) begin
        ctl_wdata_q <= reg_wdata[CTRL_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // conversion trigger
  // ----------------------------------------------------------------
  // rising edge of a clock or logic signal starts a run
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      trig_prev_q <= 1'b0;
      soc_q <= 1'b0;
    end else begin
      trig_prev_q <= ext_trig;
      soc_q <= ext_trig & ~trig_prev_q; // see [RQ15]
    end
  end

  // ----------------------------------------------------------------
  // reads: status poll and result transfer
  // ----------------------------------------------------------------
  // unmapped addresses read as zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL: begin
          rdata_q <= DATA_W'(link.stat); // see [RQ18]
        end
        ADDR_RESULT: begin
          rdata_q <= DATA_W'(link.res_data);
        end
        default: begin
          rdata_q <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // link drive
  // ----------------------------------------------------------------
  // result read acknowledges completion in the read cycle
  assign link.res_rd = reg_rd & (reg_addr == ADDR_RESULT); // see [RQ19]
  assign link.ctl_wr = ctl_wr_q;
  assign link.ctl_wdata = ctl_wdata_q; // see [RQ8]
  assign link.soc = soc_q;
  assign reg_rdata = rdata_q;
  // done level for an interrupt or a DMA request line
  assign done_req = link.eoc; // see [RQ18]

endmodule : sdc_host_ctl

// *** verif/sdc_link_chk.sv ***
`timescale 1ns/100ps
module sdc_link_chk import sdc_pkg::*; (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ctl_wr,
  input wire logic [CTRL_W-1:0] ctl_wdata,
  input wire logic soc,
  input wire logic res_rd,
  input wire logic [RES_W-1:0] res_data,
  input wire logic eoc,
  input wire logic [STAT_W-1:0] stat
);
  // ------
  // helper state
  // ------
  logic busy;
  logic single;
  logic cont;
  logic [15:0] gap_q;
  logic seen_q;
  assign busy = stat[STAT_BUSY_BIT];
  assign single = stat[STAT_MODE_LSB+:2] == MODE_SINGLE;
  assign cont = stat[STAT_MODE_LSB+:2] == MODE_CONT;

  // cycles since start or since the last new result
  always_ff @(posedge sys_clk) begin
    if (srst || !busy || $rose(eoc)) begin
      gap_q <= 16'h0000;
    end else if (gap_q != 16'hffff) begin
      gap_q <= gap_q + 16'h0001;
    end
  end

  // first result of a run seen
  always_ff @(posedge sys_clk) begin
    if (srst || !busy) begin
      seen_q <= 1'b0;
    end else if ($rose(eoc)) begin
      seen_q <= 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  // ------
  // properties
  // ------
  a_done_mirror: assert property (
    eoc == stat[STAT_DONE_BIT])
    else $error("done flag and status differ");
  a_done_holds: assert property (
    eoc && !res_rd && !ctl_wr |=> eoc)
    else $error("done dropped without a read");
  a_read_clears: assert property (
    res_rd && eoc && single |=> !eoc && !busy)
    else $error("single read left done or busy");
  a_start_runs: assert property (
    ctl_wr && ctl_wdata[CTRL_START_BIT]
    && !ctl_wdata[CTRL_STOP_BIT] && !busy |=> busy)
    else $error("start bit did not start");
  a_trig_runs: assert property (
    soc && !busy && !ctl_wr |=> busy)
    else $error("trigger did not start");
  a_mode_loads: assert property (
    ctl_wr |=> stat[STAT_MODE_LSB+:2] == $past(ctl_wdata[CTRL_MODE_LSB+:2]))
    else $error("mode not loaded");
  a_rise_busy: assert property ($rose(eoc) |-> busy)
    else $error("result while idle");
  a_prime_delay: assert property (
    $rose(eoc) && (!seen_q || !cont) |-> gap_q >= 14 * MOD_DIV_CYC)
    else $error("result before decimator primed");
  a_cont_rate: assert property (
    $rose(eoc) && seen_q && cont |->
    gap_q inside {[OSR_LO * MOD_DIV_CYC - 8 : OSR_HI * MOD_DIV_CYC + 8]})
    else $error("continuous result rate off");

  c_single: cover property ($rose(eoc) && single);
  c_cont: cover property ($rose(eoc) && cont && seen_q);
  c_multi: cover property ($rose(eoc) && !single && !cont && seen_q);
endmodule : sdc_link_chk

// *** verif/tb_sigma_delta_adc_conversion_control.sv ***
`timescale 1ns/100ps
module tb_sigma_delta_adc_conversion_control import sdc_pkg::*;;
  logic sys_clk, srst, reg_wr, reg_rd, ext_trig, done_req, mod_bit, mod_en;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic [31:0] rng_q;
  logic eoc_prev;
  int n_errors, checks;
  int exp_q[$];
  int men_cnt;
  logic [RES_W-1:0] res_now;

  // ------
  // design and checker
  // ------
  sdc_link_if sdc_link_if_inst ();
  sdc_adc_ctrl sdc_adc_ctrl_inst (.sys_clk(sys_clk), .srst(srst),
    .link(sdc_link_if_inst.dev), .mod_bit(mod_bit), .mod_en(mod_en));
  sdc_host_ctl sdc_host_ctl_inst (.sys_clk(sys_clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_trig(ext_trig),
    .done_req(done_req), .link(sdc_link_if_inst.ctl));
  sdc_link_chk sdc_link_chk_inst (.sys_clk(sys_clk), .srst(srst),
    .ctl_wr(sdc_link_if_inst.ctl_wr), .ctl_wdata(sdc_link_if_inst.ctl_wdata),
    .soc(sdc_link_if_inst.soc), .res_rd(sdc_link_if_inst.res_rd),
    .res_data(sdc_link_if_inst.res_data), .eoc(sdc_link_if_inst.eoc),
    .stat(sdc_link_if_inst.stat));
  assign res_now = sdc_link_if_inst.res_data;

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ------
  // helpers
  // ------
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction : xs

  // expected word i of a run, -1 while the input switch settles
  function automatic int expv(bit b, bit r8, int i, int n0, int skip);
    bit v;
    if (i >= n0 && i < n0 + skip) return -1;
    v = (i < n0) ? b : !b;
    if (!v) return 0;
    return r8 ? int'(RES_MAX_LO) : int'(RES_MAX_HI);
  endfunction : expv

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  task automatic fail(input string msg);
    $display("MISMATCH t=%0t %s", $time, msg);
    n_errors++;
  endtask : fail

  task automatic cmp_word(input logic [DATA_W-1:0] got, input int exp);
    if (exp < 0) return;
    checks++;
    if (got !== DATA_W'(exp)) fail("word value");
  endtask : cmp_word

  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) fail("flag value");
  endtask : cmp_bit

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic wait_done();
    bit ok;
    ok = 1'b0;
    for (int i = 0; i < 20000 && !ok; i++) begin
      @(posedge sys_clk);
      ok = (done_req === 1'b1);
    end
    if (!ok) begin
      fail("no result in time");
      give_verdict();
    end
  endtask : wait_done

  // one mode: n0 words on a random level, then n1 on its inverse
  task automatic run(input logic [1:0] m, input bit trig, input bit r8,
                     input int n0, input int n1, input int skip);
    logic [DATA_W-1:0] d;
    bit b;
    rng_q = xs(rng_q);
    b = rng_q[0];
    @(posedge sys_clk);
    mod_bit <= b;
    for (int i = 0; i < n0 + n1; i++) begin
      exp_q.push_back(expv(b, r8, i, n0, skip));
    end
    wr(ADDR_CTRL, DATA_W'({r8, m}));
    if (trig) begin
      @(posedge sys_clk);
      ext_trig <= 1'b1;
      @(posedge sys_clk);
      ext_trig <= 1'b0;
    end else begin
      wr(ADDR_CTRL, DATA_W'({1'b1, r8, m}));
    end
    for (int i = 0; i < n0 + n1; i++) begin
      wait_done();
      if (i == n0 - 1) begin
        @(posedge sys_clk);
        mod_bit <= !b;
      end
      rd(ADDR_RESULT, d);
      cmp_word(d, expv(b, r8, i, n0, skip));
      cmp_bit(done_req, 1'b0);
    end
    if (m != MODE_SINGLE) wr(ADDR_CTRL, DATA_W'({2'b10, r8, m}));
    rd(ADDR_CTRL, d);
    cmp_word(d, int'({r8, m, 2'b00}));
    $display("test mode %0d res8 %0d done", m, r8);
  endtask : run

  // ------
  // result monitor and main sequence
  // ------
  always @(posedge sys_clk) begin
    eoc_prev <= sdc_link_if_inst.eoc;
    if (sdc_link_if_inst.eoc === 1'b1 && eoc_prev === 1'b0) begin
      if (exp_q.size() == 0) fail("result not expected");
      else cmp_word(DATA_W'(res_now), exp_q.pop_front());
    end
  end

  // modulator strobe spacing against the divider count
  always @(posedge sys_clk) begin
    if (srst) begin
      men_cnt <= 0;
    end else if (mod_en === 1'b1) begin
      if (men_cnt > 0) cmp_word(DATA_W'(men_cnt), MOD_DIV_CYC);
      men_cnt <= 1;
    end else if (men_cnt > 0) begin
      men_cnt <= men_cnt + 1;
    end
  end

  initial begin
    logic [DATA_W-1:0] d;
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    ext_trig = 1'b0;
    mod_bit = 1'b0;
    rng_q = 32'hef43177a;
    n_errors = 0;
    checks = 0;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    for (int a = 0; a < 4; a++) begin
      rd(ADDR_W'(a), d);
      cmp_word(d, 0);
    end
    run(MODE_SINGLE, 1'b0, 1'b0, 1, 0, 0);
    run(MODE_MULTI, 1'b1, 1'b1, 1, 2, 0);
    run(MODE_CONT, 1'b0, 1'b1, 2, 5, 4);
    run(MODE_TURBO, 1'b1, 1'b1, 1, 2, 0);
    run(MODE_SINGLE, 1'b1, 1'b1, 1, 0, 0);
    repeat (4) @(posedge sys_clk);
    cmp_bit(exp_q.size() == 0, 1'b1);
    give_verdict();
  end
endmodule : tb_sigma_delta_adc_conversion_control
